// ---- slsu_pkg.sv ----
// Shared constants, mode table and arithmetic for the lane sample unpacker
package slsu_pkg;
	localparam int NUM_LANES   = 8;
	localparam int OCT_PER_CYC = 4;
	localparam int ACC_OCTETS  = 16;
	localparam int NUM_SLOTS   = 16;
	localparam int LANE_BITS   = 32;
	localparam int FIFO_DEPTH  = 32;

	// Register offsets
	localparam logic [11:0] ADDR_MODE     = 12'h110;
	localparam logic [11:0] ADDR_INTERP   = 12'h111;
	localparam logic [11:0] ADDR_LINK_PD  = 12'h200;
	localparam logic [11:0] ADDR_LANE_PD  = 12'h201;
	localparam logic [11:0] ADDR_PLL_STAT = 12'h281;

	// Values after reset
	localparam logic [7:0] RST_MODE    = 8'h00;
	localparam logic [7:0] RST_INTERP  = 8'h01;
	localparam logic       RST_LINK_PD = 1'b1;
	localparam logic [7:0] RST_LANE_PD = 8'h00;

	// Field positions
	localparam int LINK_PD_BIT  = 0;
	localparam int STAT_LOCK    = 0;
	localparam int STAT_CAL     = 1;
	localparam int STAT_BADMODE = 2;

	// Timing
	localparam int CLK_PERIOD_PS = 8000;
	localparam int TERM_CAL_NS   = 1000;
	localparam int PLL_TUNE_NS   = 4000;
	localparam logic [9:0] TERM_CAL_CYC =
		10'((TERM_CAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [9:0] PLL_TUNE_CYC =
		10'((PLL_TUNE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// Clock relationships
	localparam int DAC_CLK_MHZ   = 12000;
	localparam int LINE_BITS     = 10;
	localparam int LANE_MIN_MBPS = 3000;
	localparam int LANE_MAX_MBPS = 15000;
	localparam int BAND1_MBPS    = 6000;
	localparam int BAND2_MBPS    = 12000;

	typedef enum logic [1:0] {
		ST_PWR_DOWN = 2'b00,
		ST_TERM_CAL = 2'b01,
		ST_PLL_TUNE = 2'b11,
		ST_LOCKED   = 2'b10
	} slsu_link_e;

	typedef struct packed {
		logic [3:0] lanes;
		logic [3:0] convs;
		logic [3:0] octets;
		logic [4:0] bits;
		logic       ok;
	} slsu_mode_s;

	// Link parameters of each supported mode
	function automatic slsu_mode_s slsu_mode_params(input logic [7:0] m);
		slsu_mode_s p;
		p = '{lanes: 4'h1, convs: 4'h2, octets: 4'h4, bits: 5'h10, ok: 1'b1};
		case (m)
			8'h00: p = '{lanes: 4'h1, convs: 4'h2, octets: 4'h4, bits: 5'h10, ok: 1'b1};
			8'h01: p = '{lanes: 4'h2, convs: 4'h4, octets: 4'h4, bits: 5'h10, ok: 1'b1};
			8'h02: p = '{lanes: 4'h3, convs: 4'h6, octets: 4'h4, bits: 5'h10, ok: 1'b1};
			8'h05: p = '{lanes: 4'h1, convs: 4'h2, octets: 4'h3, bits: 5'h0C, ok: 1'b1};
			8'h06: p = '{lanes: 4'h2, convs: 4'h4, octets: 4'h3, bits: 5'h0C, ok: 1'b1};
			8'h07: p = '{lanes: 4'h1, convs: 4'h4, octets: 4'h8, bits: 5'h10, ok: 1'b1};
			8'h0C: p = '{lanes: 4'h8, convs: 4'h2, octets: 4'h3, bits: 5'h0C, ok: 1'b1};
			default: p.ok = 1'b0;
		endcase
		return p;
	endfunction : slsu_mode_params

	// Lane rate in Mbit/s from mode and total interpolation
	function automatic int slsu_lane_mbps(input slsu_mode_s p, input logic [7:0] interp);
		int den;
		den = 8 * int'(p.lanes) * int'(interp);
		if (den == 0 || !p.ok)
			return 0;
		return (DAC_CLK_MHZ * int'(p.convs) * int'(p.bits) * LINE_BITS) / den;
	endfunction : slsu_lane_mbps

	// Divider range for a lane rate
	function automatic logic [1:0] slsu_band(input int mbps);
		if (mbps < BAND1_MBPS)
			return 2'h0;
		if (mbps < BAND2_MBPS)
			return 2'h1;
		return 2'h2;
	endfunction : slsu_band
endpackage : slsu_pkg

// ---- slsu_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module slsu_fifo #(
	parameter int WIDTH = 256,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] wptr;
		logic [AW:0] rptr;
	} slsu_fifo_s;

	slsu_fifo_s       fifo_reg;
	slsu_fifo_s       fifo_next;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	// Full when pointers differ only in the wrap bit
	assign in_ready  = (fifo_reg.wptr != {~fifo_reg.rptr[AW], fifo_reg.rptr[AW-1:0]});
	assign out_valid = (fifo_reg.wptr != fifo_reg.rptr);
	assign out_data  = mem[fifo_reg.rptr[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer update, flush empties without touching storage
	always_comb begin
		fifo_next = fifo_reg;
		if (flush) begin
			fifo_next.rptr = fifo_reg.wptr;
		end else begin
			if (push)
				fifo_next.wptr = fifo_reg.wptr + 1'b1;
			if (pop)
				fifo_next.rptr = fifo_reg.rptr + 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset)
			fifo_reg <= '0;
		else
			fifo_reg <= fifo_next;
	end

	// Storage, written only on an accepted push
	always_ff @(posedge clk) begin
		if (push && !flush)
			mem[fifo_reg.wptr[AW-1:0]] <= in_data;
	end
endmodule : slsu_fifo

// ---- slsu_unpacker.sv ----
// Lane transport unpacker with link power, calibration and lane PLL control
`timescale 1ns/100ps
module slsu_unpacker (
	input  wire logic                                          clk,
	input  wire logic                                          reset,
	input  wire logic                                          reg_wr,
	input  wire logic                                          reg_rd,
	input  wire logic [11:0]                                   reg_addr,
	input  wire logic [7:0]                                    reg_wdata,
	output logic      [7:0]                                    reg_rdata,
	input  wire logic [slsu_pkg::NUM_LANES*slsu_pkg::LANE_BITS-1:0] lane_word,
	input  wire logic                                          lane_word_valid,
	output logic                                               lane_word_ready,
	output logic      [slsu_pkg::NUM_SLOTS-1:0][15:0]          sample_data,
	output logic                                               sample_valid,
	input  wire logic                                          sample_ready,
	output logic      [slsu_pkg::NUM_LANES-1:0]                lane_active,
	output logic                                               pll_lock,
	output logic      [1:0]                                    pll_band,
	output logic      [7:0]                                    pll_ratio_num,
	output logic      [15:0]                                   pll_ratio_den
);
	localparam int WORD_W = slsu_pkg::NUM_LANES * slsu_pkg::LANE_BITS;

	typedef struct packed {
		logic [7:0]                  mode;
		logic [7:0]                  interp;
		logic                        link_pd;
		logic [7:0]                  lane_pd;
		slsu_pkg::slsu_link_e        link;
		logic [9:0]                  timer;
		logic                        cal_done;
		logic                        locked;
		logic [1:0]                  band;
		logic [7:0]                  num;
		logic [15:0]                 den;
		logic [7:0][15:0][7:0]       acc;
		logic [4:0]                  cnt;
		logic                        out_valid;
		logic [15:0][15:0]           samp;
		logic [7:0]                  rdata;
	} slsu_core_s;

	slsu_core_s           core_reg;
	slsu_core_s           core_next;
	slsu_pkg::slsu_mode_s mp;
	int                   lane_mbps;
	logic                 rate_ok;
	logic                 running;
	logic                 cfg_wr;
	logic                 take;
	logic                 load;
	logic [4:0]           base;
	logic                 fifo_in_ready;
	logic                 fifo_out_valid;
	logic                 fifo_out_ready;
	logic [WORD_W-1:0]    fifo_out_data;
	logic [WORD_W-1:0]    masked_word;

	// PLL ratio terms; operands widened first so the product is not cut short
	function automatic logic [7:0] slsu_ratio_num(input slsu_pkg::slsu_mode_s p);
		return 8'(int'(p.convs) * int'(p.bits));
	endfunction : slsu_ratio_num

	function automatic logic [15:0] slsu_ratio_den(input slsu_pkg::slsu_mode_s p,
		input logic [7:0] interp);
		return 16'(8 * int'(p.lanes) * int'(interp));
	endfunction : slsu_ratio_den

	// Mode decode and lane rate
	// lane rate
	assign mp        = slsu_pkg::slsu_mode_params(core_reg.mode);
	assign lane_mbps = slsu_pkg::slsu_lane_mbps(mp, core_reg.interp);
	assign rate_ok   = mp.ok && (lane_mbps >= slsu_pkg::LANE_MIN_MBPS)
		&& (lane_mbps <= slsu_pkg::LANE_MAX_MBPS);
	assign running   = (core_reg.link == slsu_pkg::ST_LOCKED);
	assign cfg_wr    = reg_wr && (reg_addr == slsu_pkg::ADDR_MODE
		|| reg_addr == slsu_pkg::ADDR_INTERP || reg_addr == slsu_pkg::ADDR_LINK_PD);

	// Powered-down lanes feed zeros rather than stale octets
	// lane masking
	always_comb begin
		masked_word = lane_word;
		for (int l = 0; l < slsu_pkg::NUM_LANES; l++) begin
			if (core_reg.lane_pd[l])
				masked_word[l*slsu_pkg::LANE_BITS +: slsu_pkg::LANE_BITS] = '0;
		end
	end

	// no traffic until the link is up
	assign lane_word_ready = fifo_in_ready && running;

	slsu_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (slsu_pkg::FIFO_DEPTH)
	) slsu_fifo_inst (
		.clk       (clk),
		.reset     (reset),
		.flush     (!running),
		.in_valid  (lane_word_valid && running),
		.in_ready  (fifo_in_ready),
		.in_data   (masked_word),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// Accumulator admits a quad-octet word only while room for four remains
	// four bytes a cycle
	assign fifo_out_ready = running
		&& (core_reg.cnt <= 5'(slsu_pkg::ACC_OCTETS - slsu_pkg::OCT_PER_CYC));
	assign load = fifo_out_valid && fifo_out_ready;
	assign take = running && (core_reg.cnt >= {1'b0, mp.octets})
		&& (!core_reg.out_valid || sample_ready);
	assign base = take ? core_reg.cnt - {1'b0, mp.octets} : core_reg.cnt;

	// Next-state logic for registers, link sequencer and unpacker
	always_comb begin
		core_next = core_reg;
		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				slsu_pkg::ADDR_MODE:    core_next.mode = reg_wdata;
				slsu_pkg::ADDR_INTERP:  core_next.interp = reg_wdata;
				slsu_pkg::ADDR_LINK_PD: core_next.link_pd = reg_wdata[slsu_pkg::LINK_PD_BIT];
				slsu_pkg::ADDR_LANE_PD: core_next.lane_pd = reg_wdata;
				default:                core_next.mode = core_reg.mode;
			endcase
		end
		// Read data held until the next read; unmapped reads give zero
		if (reg_rd) begin
			case (reg_addr)
				slsu_pkg::ADDR_MODE:    core_next.rdata = core_reg.mode;
				slsu_pkg::ADDR_INTERP:  core_next.rdata = core_reg.interp;
				slsu_pkg::ADDR_LINK_PD: core_next.rdata = {7'h00, core_reg.link_pd};
				slsu_pkg::ADDR_LANE_PD: core_next.rdata = core_reg.lane_pd;
				slsu_pkg::ADDR_PLL_STAT: begin
					core_next.rdata = 8'h00;
					core_next.rdata[slsu_pkg::STAT_LOCK] = core_reg.locked;
					core_next.rdata[slsu_pkg::STAT_CAL] = core_reg.cal_done;
					core_next.rdata[slsu_pkg::STAT_BADMODE] = !mp.ok;
				end
				default: core_next.rdata = 8'h00;
			endcase
		end

		// Link sequencer: power, termination calibration, PLL tuning
		// held down while the power bit is set
		if (core_next.link_pd) begin
			core_next.link = slsu_pkg::ST_PWR_DOWN;
			core_next.timer = 10'h000;
			core_next.cal_done = 1'b0;
			core_next.locked = 1'b0;
		end else if (cfg_wr || core_reg.link == slsu_pkg::ST_PWR_DOWN) begin
			core_next.link = slsu_pkg::ST_TERM_CAL;
			core_next.timer = slsu_pkg::TERM_CAL_CYC;
			core_next.cal_done = 1'b0;
			core_next.locked = 1'b0;
		end else begin
			case (core_reg.link)
				slsu_pkg::ST_TERM_CAL: begin
					core_next.timer = core_reg.timer - 10'h001;
					if (core_reg.timer == 10'h001) begin
						core_next.link = slsu_pkg::ST_PLL_TUNE;
						core_next.timer = slsu_pkg::PLL_TUNE_CYC;
						core_next.cal_done = 1'b1;
					end
				end
				// automatic tuning, no lock outside the range
				slsu_pkg::ST_PLL_TUNE: begin
					if (!rate_ok) begin
						core_next.timer = slsu_pkg::PLL_TUNE_CYC;
					end else if (core_reg.timer == 10'h001) begin
						core_next.link = slsu_pkg::ST_LOCKED;
						core_next.locked = 1'b1;
						core_next.band = slsu_pkg::slsu_band(lane_mbps);
						// PCLK over reference is M*NP over 8*L*interp
						// reference is DAC clock over four
						core_next.num = slsu_ratio_num(mp);
						core_next.den = slsu_ratio_den(mp, core_reg.interp);
					end else begin
						core_next.timer = core_reg.timer - 10'h001;
					end
				end
				slsu_pkg::ST_LOCKED: core_next.timer = 10'h000;
				default: core_next.link = slsu_pkg::ST_PWR_DOWN;
			endcase
		end

		// Output holding register drains on ready
		if (sample_ready)
			core_next.out_valid = 1'b0;
		if (!running) begin
			core_next.cnt = 5'h00;
			core_next.out_valid = 1'b0;
		end else begin
			// frame routed to slots by mode
			if (take) begin
				core_next.out_valid = 1'b1;
				core_next.samp = '0;
				case (mp.octets)
					4'h3: begin
						for (int l = 0; l < slsu_pkg::NUM_LANES; l++) begin
							if (l < int'(mp.lanes)) begin
								core_next.samp[2*l] = {core_reg.acc[l][0],
									core_reg.acc[l][1][7:4], 4'h0};
								core_next.samp[2*l+1] = {core_reg.acc[l][1][3:0],
									core_reg.acc[l][2], 4'h0};
							end
						end
					end
					// high byte first, two converters a lane
					4'h4: begin
						for (int l = 0; l < slsu_pkg::NUM_LANES; l++) begin
							if (l < int'(mp.lanes)) begin
								core_next.samp[2*l] = {core_reg.acc[l][0], core_reg.acc[l][1]};
								core_next.samp[2*l+1] = {core_reg.acc[l][2], core_reg.acc[l][3]};
							end
						end
					end
					4'h8: begin
						for (int k = 0; k < 4; k++)
							core_next.samp[k] = {core_reg.acc[0][2*k], core_reg.acc[0][2*k+1]};
					end
					default: core_next.out_valid = 1'b0;
				endcase
				// drop the F octets just unpacked
				for (int l = 0; l < slsu_pkg::NUM_LANES; l++) begin
					for (int i = 0; i < slsu_pkg::ACC_OCTETS; i++) begin
						if (i + int'(mp.octets) < slsu_pkg::ACC_OCTETS)
							core_next.acc[l][i] = core_reg.acc[l][i + int'(mp.octets)];
						else
							core_next.acc[l][i] = 8'h00;
					end
				end
			end
			// all eight lanes advance together; octet 0 in the top byte
			if (load) begin
				for (int l = 0; l < slsu_pkg::NUM_LANES; l++) begin
					for (int j = 0; j < slsu_pkg::OCT_PER_CYC; j++)
						core_next.acc[l][int'(base) + j] =
							fifo_out_data[l*slsu_pkg::LANE_BITS + 31 - 8*j -: 8];
				end
			end
			core_next.cnt = base + (load ? 5'(slsu_pkg::OCT_PER_CYC) : 5'h00);
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (reset) begin
			core_reg <= '0;
			core_reg.mode <= slsu_pkg::RST_MODE;
			core_reg.interp <= slsu_pkg::RST_INTERP;
			core_reg.link_pd <= slsu_pkg::RST_LINK_PD;
			core_reg.lane_pd <= slsu_pkg::RST_LANE_PD;
			core_reg.link <= slsu_pkg::ST_PWR_DOWN;
		end else begin
			core_reg <= core_next;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata     = core_reg.rdata;
	assign sample_data   = core_reg.samp;
	assign sample_valid  = core_reg.out_valid;
	assign lane_active   = ~core_reg.lane_pd & {8{!core_reg.link_pd}};
	assign pll_lock      = core_reg.locked;
	assign pll_band      = core_reg.band;
	assign pll_ratio_num = core_reg.num;
	assign pll_ratio_den = core_reg.den;

	// Checks on the block's own behaviour
	localparam int AST_TUNE_MAX = 600;
	default clocking ast_cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_pwr_up;
		$fell(core_reg.link_pd);
	endsequence
	sequence s_cal_end;
		core_reg.link == slsu_pkg::ST_TERM_CAL && core_reg.timer == 10'h001
			&& !cfg_wr && !core_next.link_pd;
	endsequence
	sequence s_tune_start;
		$rose(core_reg.link == slsu_pkg::ST_PLL_TUNE) && rate_ok && !cfg_wr;
	endsequence

	AST_PD_IDLE: assert property (core_reg.link_pd |-> core_reg.link == slsu_pkg::ST_PWR_DOWN
		&& !lane_word_ready && !pll_lock)
		else $error("link active while powered down");
	AST_PWRUP_CAL: assert property (s_pwr_up |-> core_reg.link == slsu_pkg::ST_TERM_CAL
		&& core_reg.timer == slsu_pkg::TERM_CAL_CYC)
		else $error("power-up did not start calibration");
	AST_CAL_END: assert property (s_cal_end |=> core_reg.link == slsu_pkg::ST_PLL_TUNE
		&& core_reg.cal_done)
		else $error("calibration did not hand over to tuning");
	AST_TUNE_BOUND: assert property (s_tune_start |-> ##[1:AST_TUNE_MAX]
		(core_reg.locked || core_reg.link != slsu_pkg::ST_PLL_TUNE))
		else $error("lane pll did not lock in time");
	AST_BAND: assert property (core_reg.locked |-> rate_ok
		&& core_reg.band == slsu_pkg::slsu_band(lane_mbps))
		else $error("locked outside range or wrong band");
	AST_RATIO: assert property ($rose(core_reg.locked) |->
		core_reg.num == slsu_ratio_num(mp)
		&& core_reg.den == slsu_ratio_den(mp, core_reg.interp))
		else $error("pll ratio does not match mode");
	AST_STATUS: assert property (reg_rd && reg_addr == slsu_pkg::ADDR_PLL_STAT |=>
		reg_rdata[slsu_pkg::STAT_LOCK] == $past(core_reg.locked))
		else $error("status lock bit wrong");
	AST_LANE_PD: assert property (reg_wr && reg_addr == slsu_pkg::ADDR_LANE_PD
		&& !core_reg.link_pd |=> lane_active == ~$past(reg_wdata))
		else $error("lane power not applied");
	AST_F3_MAP: assert property (take && mp.octets == 4'h3 |=>
		sample_data[1] == {$past(core_reg.acc[0][1][3:0]), $past(core_reg.acc[0][2]), 4'h0})
		else $error("12-bit second sample misplaced");
	AST_F3_WIDE: assert property (take && mp.octets == 4'h3 && mp.lanes == 4'h8 |=>
		sample_data[14] == {$past(core_reg.acc[7][0]), $past(core_reg.acc[7][1][7:4]), 4'h0})
		else $error("eight-lane 12-bit sample misplaced");
	AST_F4_MAP: assert property (take && mp.octets == 4'h4 && mp.lanes == 4'h3 |=>
		sample_data[5] == {$past(core_reg.acc[2][2]), $past(core_reg.acc[2][3])})
		else $error("16-bit lane 2 sample misplaced");
	AST_F8_MAP: assert property (take && mp.octets == 4'h8 |=>
		sample_data[3] == {$past(core_reg.acc[0][6]), $past(core_reg.acc[0][7])})
		else $error("converter 3 sample misplaced");
	AST_HOLD: assert property (sample_valid && !sample_ready |=>
		sample_valid && $stable(sample_data))
		else $error("sample dropped under back-pressure");
	AST_RESTART: assert property (cfg_wr && !core_next.link_pd |=>
		core_reg.link == slsu_pkg::ST_TERM_CAL && !pll_lock)
		else $error("configuration did not restart calibration");
	AST_READY_LOCK: assert property (lane_word_ready |-> pll_lock)
		else $error("lane data taken before lock");
	AST_F4_FIRST: assert property (take && mp.octets == 4'h4 |=>
		sample_data[0] == {$past(core_reg.acc[0][0]), $past(core_reg.acc[0][1])})
		else $error("16-bit converter 0 sample misplaced");
	AST_F4_LANE1: assert property (take && mp.octets == 4'h4 && mp.lanes == 4'h2 |=>
		sample_data[2] == {$past(core_reg.acc[1][0]), $past(core_reg.acc[1][1])})
		else $error("16-bit lane 1 sample misplaced");
	AST_F3_LANE1: assert property (take && mp.octets == 4'h3 && mp.lanes == 4'h2 |=>
		sample_data[2] == {$past(core_reg.acc[1][0]), $past(core_reg.acc[1][1][7:4]), 4'h0})
		else $error("12-bit lane 1 sample misplaced");
	AST_ACC_ROOM: assert property (core_reg.cnt <= 5'(slsu_pkg::ACC_OCTETS))
		else $error("accumulator overfilled");
endmodule : slsu_unpacker

// ---- slsu_tx_model.sv ----
// Transmitter model that offers lane words to the unpacker
`timescale 1ns/100ps
module slsu_tx_model (
	input  wire logic         clk,
	input  wire logic         stall,
	input  wire logic         lane_word_ready,
	output logic [255:0]      lane_word,
	output logic              lane_word_valid
);
	logic [255:0] q[$];
	logic         took = 1'b0;
	// Acceptance is judged at the sampling edge only
	always @(posedge clk)
		took <= lane_word_valid & lane_word_ready;
	// Offer held until taken; idle data toggles so a stale word never matches
	initial begin
		lane_word = '0;
		lane_word_valid = 1'b0;
		forever begin
			@(negedge clk);
			if (took)
				void'(q.pop_front());
			if (!lane_word_valid || took) begin
				if (q.size() > 0 && !stall) begin
					lane_word_valid = 1'b1;
					lane_word = q[0];
				end else begin
					lane_word_valid = 1'b0;
					lane_word = ~lane_word;
				end
			end
		end
	end
endmodule : slsu_tx_model

// ---- slsu_unpacker_test.sv ----
// Self-checking bench for the lane sample unpacker
`timescale 1ns/100ps
module slsu_unpacker_test;
	logic              clk, reset, reg_wr, reg_rd, sample_ready, stall;
	logic              lane_word_valid, lane_word_ready, sample_valid, pll_lock;
	logic [11:0]       reg_addr;
	logic [7:0]        reg_wdata, reg_rdata, lane_active, rd_val, pll_ratio_num;
	logic [255:0]      lane_word;
	logic [15:0][15:0] sample_data;
	logic [1:0]        pll_band;
	logic [15:0]       pll_ratio_den;
	int                bad_count, samples_checked, cyc;

	slsu_unpacker slsu_unpacker_inst (.clk(clk), .reset(reset), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.lane_word(lane_word), .lane_word_valid(lane_word_valid),
		.lane_word_ready(lane_word_ready), .sample_data(sample_data),
		.sample_valid(sample_valid), .sample_ready(sample_ready), .lane_active(lane_active),
		.pll_lock(pll_lock), .pll_band(pll_band), .pll_ratio_num(pll_ratio_num),
		.pll_ratio_den(pll_ratio_den));
	slsu_tx_model slsu_tx_model_inst (.clk(clk), .stall(stall),
		.lane_word_ready(lane_word_ready), .lane_word(lane_word),
		.lane_word_valid(lane_word_valid));

	// Clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Cycle ceiling and a sparse transmitter stall
	always @(posedge clk) begin
		cyc <= cyc + 1;
		stall <= (cyc % 7 == 3);
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [11:0] a);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		rd_val = reg_rdata;
	endtask : rd

	// Octet n of lane l in the transmitted stream
	function automatic logic [7:0] oct(input int l, input int n);
		return 8'(l * 37 + n * 5 + 3);
	endfunction : oct

	function automatic logic [15:0] exp_slot(int f, int nl, logic [7:0] pd, int s, int j);
		int         l;
		int         k;
		logic [7:0] o1;
		l = (f == 8) ? 0 : s / 2;
		k = (f == 8) ? s : s % 2;
		if (l >= nl || pd[l] || k > 3)
			return 16'h0000;
		o1 = oct(l, j * f + 1);
		if (f != 3)
			return {oct(l, j * f + 2 * k), oct(l, j * f + 2 * k + 1)};
		if (k == 0)
			return {oct(l, j * f), o1[7:4], 4'h0};
		return {o1[3:0], oct(l, j * f + 2), 4'h0};
	endfunction : exp_slot

	// Configure, power up, await lock, stream frames and judge every slot
	task automatic run_mode(input logic [7:0] m, input logic [7:0] ip, input int f,
		input int nl, input logic [7:0] pd, input int nf, input logic [1:0] band,
		input logic [7:0] num, input logic [15:0] den, input bit hold);
		int           n;
		logic [255:0] w;
		wr(12'h200, 8'h01);
		wr(12'h110, m);
		wr(12'h111, ip);
		wr(12'h201, pd);
		for (int i = 0; i < nf * f / 4; i++) begin
			for (int l = 0; l < 8; l++)
				w[32*l +: 32] = {oct(l, 4*i), oct(l, 4*i+1), oct(l, 4*i+2), oct(l, 4*i+3)};
			slsu_tx_model_inst.q.push_back(w);
		end
		sample_ready = !hold;
		wr(12'h200, 8'h00);
		n = 0;
		check(lane_word_ready, 16'h0000);
		check({8'h00, lane_active}, {8'h00, ~pd});
		while (pll_lock !== 1'b1 && n < 700) begin
			@(negedge clk);
			n++;
		end
		check(16'(n), 16'h0271);
		check(pll_band, band);
		check(pll_ratio_num, num);
		check(pll_ratio_den, den);
		rd(12'h281);
		check(rd_val, 8'h03);
		if (hold) begin
			repeat (60) @(negedge clk);
			check(lane_word_ready, 16'h0000);
			check(16'(slsu_tx_model_inst.q.size() > 0), 16'h0001);
			sample_ready = 1'b1;
		end
		for (int j = 0; j < nf; j++) begin
			n = 0;
			while (sample_valid !== 1'b1 && n < 50) begin
				@(negedge clk);
				n++;
			end
			for (int s = 0; s < 16; s++)
				check(sample_data[s], exp_slot(f, nl, pd, s, j));
			@(negedge clk);
		end
		// Lane power applies while the link is up
		wr(12'h201, ~pd);
		check({8'h00, lane_active}, {8'h00, pd});
		$display("test mode %h done", m);
	endtask : run_mode

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	// Main sequence
	initial begin
		reset = 1'b1;
		{reg_wr, reg_rd, sample_ready} = 3'b000;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		repeat (16) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		rd(12'h110);
		check(rd_val, slsu_pkg::RST_MODE);
		rd(12'h111);
		check(rd_val, slsu_pkg::RST_INTERP);
		rd(12'h200);
		check(rd_val, {7'h00, slsu_pkg::RST_LINK_PD});
		rd(12'h201);
		check(rd_val, slsu_pkg::RST_LANE_PD);
		wr(12'h281, 8'hFF);
		rd(12'h281);
		check(rd_val, 8'h00);
		rd(12'h3FF);
		check(rd_val, 8'h00);
		wr(12'h201, 8'hA5);
		rd(12'h201);
		check(rd_val, 8'hA5);
		check({8'h00, lane_active}, 16'h0000);
		$display("test registers done");
		run_mode(8'h00, 8'h78, 4, 1, 8'hFE, 48, 2'h0, 8'h20, 16'h03C0, 1'b1);
		run_mode(8'h01, 8'h30, 4, 2, 8'h02, 4, 2'h1, 8'h40, 16'h0300, 1'b0);
		run_mode(8'h02, 8'h30, 4, 3, 8'hF8, 4, 2'h1, 8'h60, 16'h0480, 1'b0);
		run_mode(8'h05, 8'h30, 3, 1, 8'hFE, 4, 2'h1, 8'h18, 16'h0180, 1'b0);
		run_mode(8'h06, 8'h30, 3, 2, 8'hFC, 4, 2'h1, 8'h30, 16'h0300, 1'b0);
		run_mode(8'h07, 8'h60, 8, 1, 8'hFE, 2, 2'h1, 8'h40, 16'h0300, 1'b0);
		run_mode(8'h0C, 8'h03, 3, 8, 8'h00, 4, 2'h2, 8'h18, 16'h00C0, 1'b0);
		wr(12'h200, 8'h01);
		wr(12'h110, 8'h03);
		wr(12'h200, 8'h00);
		repeat (700) @(negedge clk);
		rd(12'h281);
		check({rd_val[2], rd_val[0]}, 16'h0002);
		$display("test unsupported mode done");
		summarize();
	end
endmodule : slsu_unpacker_test
